// ---- rtl/uart_flow_dma.sv ----
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "uart_flow_regs.svh"

module uart_flow_dma
	import uart_flow_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic             PREADY_O,
	output logic      [31:0] PRDATA_O,
	output logic             PSLVERR_O,
	input  wire logic        RX_VALID_I,
	input  wire logic [7:0]  RX_DATA_I,
	input  wire logic [2:0]  RX_ERR_I,
	input  wire logic        RX_START_I,
	input  wire logic        RX_LINE_I,
	input  wire logic        DMA_ACK_I,
	input  wire logic        DMA_CHAIN_END_I,
	output logic             DMA_RX_REQ_O,
	output logic      [6:0]  DMA_REQ_BYTES_O,
	output logic             DMA_DONE_O,
	output logic      [31:0] DMA_DATA_O,
	output logic      [2:0]  DMA_VALID_BYTES_O,
	output logic             DMA_EOR_O,
	input  wire logic        TX_REQ_I,
	input  wire logic        CTS_N_I,
	output logic             TX_GO_O,
	output logic             RTS_N_O,
	output logic      [15:0] DIV_O
);

	// Rounds a formula divisor to a common rate below the fast band.
	function automatic logic [15:0] table_div(input logic [15:0] f);
		if (f <= `TBL_FAST_MAX)      return f;
		else if (f < `TBL_CUT_64)    return `DIV_19200;
		else if (f < `TBL_CUT_96)    return `DIV_14400;
		else if (f < `TBL_CUT_192)   return `DIV_9600;
		else if (f < `TBL_CUT_768)   return `DIV_4800;
		else if (f < `TBL_CUT_3072)  return `DIV_1200;
		else                         return `DIV_300;
	endfunction

	logic [13:0]      fifo_control_reg;
	logic [2:0]       irq_enable_reg;
	logic [5:0]       modem_control_reg;
	logic [2:0]       autobaud_control_reg;
	logic [15:0]      autobaud_count_reg;
	logic [5:0]       wr_ptr_q, rd_ptr_q, rd_addr;
	logic [6:0]       count_q, err_cnt_q, thr;
	rx_entry_type     head;
	gather_state_type st_q;
	logic             owner_dma_q, apb_busy_q, eor_pend_q, eor_act_q;
	logic [6:0]       eor_left_q;
	logic [2:0]       need_q, got_q;
	logic [31:0]      word_q;
	logic [15:0]      tick_cnt_q, ab_cnt_q;
	logic [9:0]       tout_cnt_q;
	logic             tick, wr, pop, take, timeout, trail, bus32, dma_en;
	logic             full_flow, cts_flow, line_q, ab_meas_q, ab_done;
	logic             eoc_q, tod_q, lock_q, setup, wr_acc, rd_acc, data_rd;
	logic [16:0]      ab_sum;
	logic [15:0]      ab_div;

	assign trail     = fifo_control_reg[`FC_TRAIL];
	assign bus32     = fifo_control_reg[`FC_BUS32];
	assign dma_en    = irq_enable_reg[`IE_DMA] && fifo_control_reg[`FC_FIFO_EN];
	assign thr       = {1'b0, fifo_control_reg[`FC_THR_HI:`FC_THR_LO]};
	// Flow control needs the FIFOs; bit 5 enables it, bit 1 adds RTS.
	assign full_flow = modem_control_reg[`MC_AUTO] && modem_control_reg[`MC_RTS] && fifo_control_reg[`FC_FIFO_EN];
	assign cts_flow  = modem_control_reg[`MC_AUTO] && fifo_control_reg[`FC_FIFO_EN];
	assign setup     = PSEL_I && !PENABLE_I;
	assign wr_acc    = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
	assign rd_acc    = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I;
	assign data_rd   = setup && !PWRITE_I && (PADDR_I == `A_RXD1 || PADDR_I == `A_RXD2 || PADDR_I == `A_RXD4);

	// Receive FIFO storage.
	assign wr      = RX_VALID_I && count_q != `FIFO_DEPTH;
	assign rd_addr = rd_ptr_q + {5'h00, pop};
	rx_entry_mem u_mem (
		.clk_i     (CLK_I),
		.wr_en_i   (wr),
		.wr_addr_i (wr_ptr_q),
		.wr_data_i ({RX_ERR_I, RX_DATA_I}),
		.rd_addr_i (rd_addr),
		.rd_data_o (head)
	);

	// Pops stop at an empty FIFO so over-reads never move the counters.
	assign take = st_q == G_GATHER && got_q < need_q && count_q != 7'h00 && !(owner_dma_q && eor_act_q && eor_left_q == 7'h00);
	assign pop  = take;

	// FIFO pointers, occupancy and number of errored entries.
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			wr_ptr_q  <= 6'h00;
			rd_ptr_q  <= 6'h00;
			count_q   <= 7'h00;
			err_cnt_q <= 7'h00;
		end
		else
		begin
			wr_ptr_q  <= wr_ptr_q + {5'h00, wr};
			rd_ptr_q  <= rd_addr;
			count_q   <= count_q + {6'h00, wr} - {6'h00, pop};
			err_cnt_q <= err_cnt_q + {6'h00, wr && RX_ERR_I != 3'h0} - {6'h00, pop && head[10:8] != 3'h0};
		end
	end

	// Byte gatherer serving both the processor and the DMA controller.
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			st_q        <= G_IDLE;
			owner_dma_q <= 1'b0;
			need_q      <= 3'h0;
			got_q       <= 3'h0;
			word_q      <= 32'h0000_0000;
		end
		else
		begin
			case (st_q)
				G_IDLE:
				begin
					got_q  <= 3'h0;
					word_q <= 32'h0000_0000;
					if (DMA_ACK_I && DMA_RX_REQ_O)
					begin
						st_q        <= G_GATHER;
						owner_dma_q <= 1'b1;
						need_q      <= bus32 ? 3'h4 : 3'h1;
					end
					else if (apb_busy_q)
					begin
						st_q        <= G_GATHER;
						owner_dma_q <= 1'b0;
						// The address picks one, two or four bytes in 32-bit mode.
						need_q      <= !bus32 ? 3'h1 : PADDR_I == `A_RXD4 ? 3'h4 : PADDR_I == `A_RXD2 ? 3'h2 : 3'h1;
					end
				end
				G_GATHER:
				begin
					if (take)
					begin
						// Byte i lands in lane i, so the latest sits highest.
						word_q[got_q[1:0]*8 +: 8] <= head[7:0];
						got_q <= got_q + 3'h1;
					end
					else
						st_q <= G_DONE;
				end
				G_DONE:
					st_q <= G_IDLE;
				default:
					st_q <= G_IDLE;
			endcase
		end
	end

	// APB handshake; data reads wait for the gatherer.
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			PREADY_O   <= 1'b0;
			PSLVERR_O  <= 1'b0;
			PRDATA_O   <= 32'h0000_0000;
			apb_busy_q <= 1'b0;
		end
		else
		begin
			PREADY_O <= 1'b0;
			if (data_rd)
				apb_busy_q <= 1'b1;
			else if (setup)
			begin
				PREADY_O  <= 1'b1;
				PSLVERR_O <= 1'b0;
				case (PADDR_I)
					`A_IDENT:      PRDATA_O <= {25'h0, lock_q, eoc_q, tod_q, err_cnt_q != 7'h00 ? `IID_LINE
					               : eoc_q ? `IID_EOC : tod_q ? `IID_TOUT : count_q >= thr ? `IID_DATA
					               : lock_q ? `IID_BAUD : `IID_NONE};
					`A_FIFO_CTRL:  PRDATA_O <= {18'h0, fifo_control_reg};
					`A_IRQ_EN:     PRDATA_O <= {29'h0, irq_enable_reg};
					`A_MODEM_CTRL: PRDATA_O <= {26'h0, modem_control_reg};
					`A_AB_CTRL:    PRDATA_O <= {29'h0, autobaud_control_reg};
					`A_AB_COUNT:   PRDATA_O <= {16'h0, autobaud_count_reg};
					`A_DIVISOR:    PRDATA_O <= {16'h0, DIV_O};
					`A_OCCUPANCY:  PRDATA_O <= {17'h0, err_cnt_q, 1'b0, count_q};
					`A_RXD1, `A_RXD2, `A_RXD4: PRDATA_O <= 32'h0000_0000;
					default:
					begin
						PRDATA_O  <= 32'h0000_0000;
						PSLVERR_O <= 1'b1;
					end
				endcase
			end
			if (st_q == G_DONE && !owner_dma_q)
			begin
				PREADY_O   <= 1'b1;
				PSLVERR_O  <= 1'b0;
				PRDATA_O   <= word_q;
				apb_busy_q <= 1'b0;
			end
		end
	end

	// Software-written control registers; detection clears its own enable.
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			fifo_control_reg     <= `RST_FIFO_CTRL;
			irq_enable_reg       <= 3'h0;
			modem_control_reg    <= 6'h00;
			autobaud_control_reg <= 3'h0;
		end
		else
		begin
			if (wr_acc && PADDR_I == `A_FIFO_CTRL)
				fifo_control_reg <= PWDATA_I[13:0];
			if (wr_acc && PADDR_I == `A_IRQ_EN)
				irq_enable_reg <= PWDATA_I[2:0];
			if (wr_acc && PADDR_I == `A_MODEM_CTRL)
				modem_control_reg <= PWDATA_I[5:0];
			if (wr_acc && PADDR_I == `A_AB_CTRL)
				autobaud_control_reg <= PWDATA_I[2:0];
			if (ab_done)
				autobaud_control_reg[`AB_ENABLE] <= 1'b0;
		end
	end

	// Formula divisor, then optional rounding to common rates.
	assign ab_sum = {1'b0, ab_cnt_q} + `ROUND_HALF;
	always_comb
	begin
		ab_div = ab_sum[16:4] == 13'h0000 ? 16'h0001 : {3'h0, ab_sum[16:4]};
		if (autobaud_control_reg[`AB_TABLE])
			ab_div = table_div(ab_div);
	end

	// Start-bit measurement; never armed in slow infrared mode.
	assign ab_done = ab_meas_q && RX_LINE_I && !autobaud_control_reg[`AB_SIR];
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			line_q    <= 1'b1;
			ab_meas_q <= 1'b0;
			ab_cnt_q  <= 16'h0000;
		end
		else
		begin
			line_q <= RX_LINE_I;
			if (autobaud_control_reg[`AB_SIR] || !autobaud_control_reg[`AB_ENABLE] || ab_done)
				ab_meas_q <= 1'b0;
			else if (!ab_meas_q && line_q && !RX_LINE_I)
			begin
				ab_meas_q <= 1'b1;
				ab_cnt_q  <= 16'h0001;
			end
			else if (ab_meas_q && ab_cnt_q != 16'hffff)
				ab_cnt_q <= ab_cnt_q + 16'h0001;
		end
	end

	// Count register and divisor, loaded by hardware after detection.
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			autobaud_count_reg <= 16'h0000;
			DIV_O              <= `RST_DIVISOR;
		end
		else if (ab_done)
		begin
			autobaud_count_reg <= ab_cnt_q;
			DIV_O              <= ab_div;
		end
		else if (wr_acc && PADDR_I == `A_DIVISOR)
			DIV_O <= PWDATA_I[15:0];
	end

	// Sixteen-times bit-rate enable and the character timeout counter.
	assign tick    = DIV_O != 16'h0000 && tick_cnt_q == DIV_O - 16'h0001;
	assign timeout = tout_cnt_q == `TOUT_TICKS && count_q != 7'h00;
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			tick_cnt_q <= 16'h0000;
			tout_cnt_q <= 10'h000;
		end
		else
		begin
			tick_cnt_q <= tick || DIV_O == 16'h0000 ? 16'h0000 : tick_cnt_q + 16'h0001;
			if (wr || pop || RX_START_I || count_q == 7'h00)
				tout_cnt_q <= 10'h000;
			else if (tick && tout_cnt_q != `TOUT_TICKS)
				tout_cnt_q <= tout_cnt_q + 10'h001;
		end
	end

	// Trailing-byte and end-of-receive tracking.
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			eor_pend_q <= 1'b0;
			eor_act_q  <= 1'b0;
			eor_left_q <= 7'h00;
		end
		else
		begin
			if (DMA_CHAIN_END_I || !trail || !dma_en)
			begin
				eor_pend_q <= 1'b0;
				eor_act_q  <= 1'b0;
			end
			else if (st_q == G_IDLE && DMA_ACK_I && DMA_RX_REQ_O && eor_pend_q && count_q < thr)
			begin
				// Freeze the byte count seen when the controller answers.
				eor_act_q  <= 1'b1;
				eor_left_q <= count_q;
			end
			else if (eor_act_q && pop)
				eor_left_q <= eor_left_q - 7'h01;
			else if (st_q == G_DONE && owner_dma_q && eor_act_q && eor_left_q == 7'h00)
			begin
				eor_act_q  <= 1'b0;
				eor_pend_q <= 1'b0;
			end
			else if (!eor_act_q && count_q >= thr)
				eor_pend_q <= 1'b0;
			else if (timeout && count_q < thr)
				eor_pend_q <= 1'b1;
		end
	end

	// DMA request and word delivery; errors hold the request off.
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			DMA_RX_REQ_O      <= 1'b0;
			DMA_REQ_BYTES_O   <= 7'h00;
			DMA_DONE_O        <= 1'b0;
			DMA_DATA_O        <= 32'h0000_0000;
			DMA_VALID_BYTES_O <= 3'h0;
			DMA_EOR_O         <= 1'b0;
		end
		else
		begin
			DMA_RX_REQ_O    <= dma_en && err_cnt_q == 7'h00 && st_q == G_IDLE && !DMA_ACK_I && !apb_busy_q
			                   && (count_q >= thr || (eor_pend_q && count_q != 7'h00));
			DMA_REQ_BYTES_O <= count_q >= thr && !eor_act_q ? thr : eor_act_q ? eor_left_q : count_q;
			DMA_DONE_O      <= st_q == G_DONE && owner_dma_q;
			if (st_q == G_DONE && owner_dma_q)
			begin
				DMA_DATA_O        <= word_q;
				DMA_VALID_BYTES_O <= got_q;
				DMA_EOR_O         <= eor_act_q && eor_left_q == 7'h00;
			end
		end
	end

	// Sticky indications; a set in the same cycle as the clearing read wins.
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			eoc_q  <= 1'b0;
			tod_q  <= 1'b0;
			lock_q <= 1'b0;
		end
		else
		begin
			if (!trail)
				eoc_q <= 1'b0;
			else if (DMA_CHAIN_END_I && (eor_pend_q || eor_act_q) && count_q != 7'h00)
				eoc_q <= 1'b1;
			else if (rd_acc && PADDR_I == `A_IDENT)
				eoc_q <= 1'b0;
			if (irq_enable_reg[`IE_RX_TIMEOUT_IRQ_ENABLE] && (timeout || (trail && DMA_CHAIN_END_I && (eor_pend_q || eor_act_q)
			    && count_q != 7'h00)))
				tod_q <= 1'b1;
			else if ((rd_acc && PADDR_I == `A_IDENT) || pop || RX_START_I)
				tod_q <= 1'b0;
			if (ab_done && irq_enable_reg[`IE_BAUD])
				lock_q <= 1'b1;
			else if (rd_acc && PADDR_I == `A_IDENT)
				lock_q <= 1'b0;
		end
	end

	// Modem handshake: RTS from FIFO level, one byte start per CTS check.
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			RTS_N_O <= 1'b1;
			TX_GO_O <= 1'b0;
		end
		else
		begin
			RTS_N_O <= full_flow ? count_q >= thr : !modem_control_reg[`MC_RTS];
			TX_GO_O <= TX_REQ_I && !TX_GO_O && (!cts_flow || !CTS_N_I);
		end
	end

	chk_rts_level: assert property (@(posedge CLK_I) disable iff (RST_I)
		full_flow && count_q >= thr |=> RTS_N_O) else $error("RTS not released at threshold");
	chk_cts_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
		cts_flow && CTS_N_I |=> !TX_GO_O) else $error("Byte started while CTS high");
	chk_err_blocks: assert property (@(posedge CLK_I) disable iff (RST_I)
		err_cnt_q != 7'h00 |=> !DMA_RX_REQ_O) else $error("DMA request with errored entries");
	chk_req_resume: assert property (@(posedge CLK_I) disable iff (RST_I)
		dma_en && err_cnt_q == 7'h00 && count_q >= thr && st_q == G_IDLE && !DMA_ACK_I && !apb_busy_q
		|=> DMA_RX_REQ_O) else $error("DMA request did not resume");
	chk_no_eoc: assert property (@(posedge CLK_I) disable iff (RST_I)
		!trail |=> !eoc_q) else $error("EOC without trailing mode");
	chk_eor_cancel: assert property (@(posedge CLK_I) disable iff (RST_I)
		!eor_act_q && count_q >= thr && trail && dma_en && !DMA_CHAIN_END_I |=> !eor_pend_q)
		else $error("END_OF_RECEIVE_FLAG kept after threshold");
	chk_abe_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
		ab_done |=> !autobaud_control_reg[`AB_ENABLE] && autobaud_count_reg == $past(ab_cnt_q))
		else $error("Detection did not store count or clear enable");
	chk_div_min: assert property (@(posedge CLK_I) disable iff (RST_I)
		ab_done |=> DIV_O != 16'h0000) else $error("Loaded divisor is zero");
	chk_sir_idle: assert property (@(posedge CLK_I) disable iff (RST_I)
		autobaud_control_reg[`AB_SIR] |=> !ab_meas_q) else $error("Measuring in infrared mode");
	chk_no_overpop: assert property (@(posedge CLK_I) disable iff (RST_I)
		pop |-> count_q != 7'h00) else $error("Pop from empty FIFO");
	chk_bus8_lane: assert property (@(posedge CLK_I) disable iff (RST_I)
		!bus32 && st_q == G_DONE && !owner_dma_q |=> PRDATA_O[31:8] == 24'h000000)
		else $error("Upper lanes used in 8-bit mode");

	cov_eoc: cover property (@(posedge CLK_I) disable iff (RST_I) $rose(eoc_q));
	cov_eor: cover property (@(posedge CLK_I) disable iff (RST_I) DMA_DONE_O && DMA_EOR_O);
	cov_baud: cover property (@(posedge CLK_I) disable iff (RST_I) ab_done);

endmodule // uart_flow_dma

// ---- rtl/uart_flow_regs.svh ----
`ifndef UART_FLOW_REGS_SVH
`define UART_FLOW_REGS_SVH

// Byte addresses of the APB registers.
`define A_RXD1          8'h00
`define A_RXD2          8'h04
`define A_RXD4          8'h08
`define A_IDENT         8'h0c
`define A_FIFO_CTRL     8'h10
`define A_IRQ_EN        8'h14
`define A_MODEM_CTRL    8'h18
`define A_AB_CTRL       8'h1c
`define A_AB_COUNT      8'h20
`define A_DIVISOR       8'h24
`define A_OCCUPANCY     8'h28

// Field positions.
`define FC_FIFO_EN      0
`define FC_TRAIL        4
`define FC_BUS32        5
`define FC_THR_LO       8
`define FC_THR_HI       13
`define IE_DMA          0
`define IE_RX_TIMEOUT_IRQ_ENABLE        1
`define IE_BAUD         2
`define MC_RTS          1
`define MC_AUTO         5
`define AB_ENABLE       0
`define AB_TABLE        1
`define AB_SIR          2
`define ID_TOD          4
`define ID_EOC          5
`define ID_BAUD         6

// Reset values.
`define RST_FIFO_CTRL   14'h0100
`define RST_DIVISOR     16'h0002

// Interrupt source codes, highest priority first.
`define IID_LINE        4'h6
`define IID_EOC         4'h8
`define IID_TOUT        4'hc
`define IID_DATA        4'h4
`define IID_BAUD        4'ha
`define IID_NONE        4'h1

// Receive FIFO geometry and counts.
`define FIFO_DEPTH      7'h40
`define TOUT_TICKS      10'h280
`define ROUND_HALF      17'h00008
`define TBL_FAST_MAX    16'h0020
`define TBL_CUT_64      16'h0038
`define TBL_CUT_96      16'h0050
`define TBL_CUT_192     16'h0090
`define TBL_CUT_768     16'h01e0
`define TBL_CUT_3072    16'h0780
`define DIV_19200       16'h0030
`define DIV_14400       16'h0040
`define DIV_9600        16'h0060
`define DIV_4800        16'h00c0
`define DIV_1200        16'h0300
`define DIV_300         16'h0c00

`endif

// ---- rtl/uart_flow_pkg.sv ----
package uart_flow_pkg;

	// Byte gatherer states, one-hot.
	typedef enum logic [2:0] {
		G_IDLE   = 3'b001,
		G_GATHER = 3'b010,
		G_DONE   = 3'b100
	} gather_state_type;

	typedef logic [10:0] rx_entry_type;

endpackage

// ---- rtl/rx_entry_mem.sv ----
`timescale 1ns/100ps
`include "uart_flow_regs.svh"

module rx_entry_mem
	import uart_flow_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         wr_en_i,
	input  wire logic [5:0]   wr_addr_i,
	input  wire rx_entry_type wr_data_i,
	input  wire logic [5:0]   rd_addr_i,
	output rx_entry_type      rd_data_o
);

	rx_entry_type mem_q [0:63];

	// Store one received entry per cycle.
	always_ff @(posedge clk_i)
	begin
		if (wr_en_i)
			mem_q[wr_addr_i] <= wr_data_i;
	end

	// Registered read; a write to the addressed slot is forwarded.
	always_ff @(posedge clk_i)
	begin
		if (wr_en_i && wr_addr_i == rd_addr_i)
			rd_data_o <= wr_data_i;
		else
			rd_data_o <= mem_q[rd_addr_i];
	end

endmodule // rx_entry_mem

// ---- test/remote_tx.sv ----
`timescale 1ns/100ps

// Remote transmitter driving the receive side of the port.
module remote_tx
(
	input  wire logic       clk_i,
	input  wire logic       rts_n_i,
	output logic            valid_o,
	output logic      [7:0] data_o,
	output logic      [2:0] err_o,
	output logic            start_o,
	output logic            line_o
);
	// A character that waited too long for request-to-send counts as a mismatch.
	int misses = 0;

	// The line rests high while no character is sent.
	initial
	begin
		valid_o = 1'b0;
		data_o  = 8'h00;
		err_o   = 3'h0;
		start_o = 1'b0;
		line_o  = 1'b1;
	end

	// Sends one character with a start bit of len clocks once data is asked for.
	task automatic send(input logic [7:0] b, input logic [2:0] e, input int len);
		int n;
		for (n = 0; n < 4000 && rts_n_i !== 1'b0; n++)
			@(posedge clk_i);
		if (n == 4000)
			misses++;
		start_o <= 1'b1;
		line_o  <= 1'b0;
		@(posedge clk_i);
		start_o <= 1'b0;
		repeat (len - 1) @(posedge clk_i);
		line_o  <= 1'b1;
		valid_o <= 1'b1;
		data_o  <= b;
		err_o   <= e;
		@(posedge clk_i);
		// Released data lines show the inverse of the last value.
		valid_o <= 1'b0;
		data_o  <= ~b;
		err_o   <= ~e;
	endtask
endmodule // remote_tx

// ---- test/testbench.sv ----
`timescale 1ns/100ps
`include "uart_flow_regs.svh"

module testbench;
	logic        CLK_I           = 1'b0;
	logic        RST_I           = 1'b1;
	logic        PSEL_I          = 1'b0;
	logic        PENABLE_I       = 1'b0;
	logic        PWRITE_I        = 1'b0;
	logic [7:0]  PADDR_I         = 8'h00;
	logic [31:0] PWDATA_I        = 32'h0;
	logic        DMA_ACK_I       = 1'b0;
	logic        DMA_CHAIN_END_I = 1'b0;
	logic        TX_REQ_I        = 1'b0;
	logic        CTS_N_I         = 1'b1;
	logic        RX_VALID_I, RX_START_I, RX_LINE_I, PREADY_O, PSLVERR_O, DMA_RX_REQ_O;
	logic        DMA_DONE_O, DMA_EOR_O, TX_GO_O, RTS_N_O, slv;
	logic [7:0]  RX_DATA_I;
	logic [2:0]  RX_ERR_I, DMA_VALID_BYTES_O;
	logic [6:0]  DMA_REQ_BYTES_O;
	logic [15:0] DIV_O;
	logic [31:0] PRDATA_O, DMA_DATA_O, rdat;
	int          num_errors      = 0;
	int          checks          = 0;
	int          go_cnt          = 0;
	int          i, g;

	// Clock of 40 ns and a count of transmit starts.
	always #20 CLK_I = ~CLK_I;
	always @(posedge CLK_I)
		if (TX_GO_O === 1'b1)
			go_cnt <= go_cnt + 1;

	uart_flow_dma uart_flow_dma_inst (.*);

	remote_tx remote_tx_inst
	(
		.clk_i   (CLK_I),
		.rts_n_i (RTS_N_O),
		.valid_o (RX_VALID_I),
		.data_o  (RX_DATA_I),
		.err_o   (RX_ERR_I),
		.start_o (RX_START_I),
		.line_o  (RX_LINE_I)
	);

	// Counts one comparison and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		num_errors = num_errors + remote_tx_inst.misses;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// A wait that used up its bound ends the run as a mismatch.
	task automatic hang();
		num_errors++;
		final_report();
	endtask

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		PSEL_I   <= 1'b1;
		PWRITE_I <= w;
		PADDR_I  <= a;
		PWDATA_I <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		for (n = 0; n < 300 && PREADY_O !== 1'b1; n++)
			@(posedge CLK_I);
		if (n == 300)
			hang();
		rdat = PRDATA_O;
		slv  = PSLVERR_O;
		PSEL_I    <= 1'b0;
		PENABLE_I <= 1'b0;
		@(posedge CLK_I);
	endtask

	// Reads a register and compares the masked value.
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat & m, e);
	endtask

	// Sends n clean bytes counting up from b.
	task automatic txn(input int n, input logic [7:0] b);
		int k;
		for (k = 0; k < n; k++)
			remote_tx_inst.send(b + 8'(k), 3'h0, 2);
	endtask

	// Waits for a receive request.
	task automatic wreq(input int lim);
		int n;
		for (n = 0; n < lim && DMA_RX_REQ_O !== 1'b1; n++)
			@(posedge CLK_I);
		if (n == lim)
			hang();
	endtask

	// Answers the request and compares the delivered word in its valid lanes.
	task automatic ack(input logic [31:0] d, input logic [2:0] v, input logic e);
		int n;
		DMA_ACK_I <= 1'b1;
		@(posedge CLK_I);
		DMA_ACK_I <= 1'b0;
		for (n = 0; n < 50 && DMA_DONE_O !== 1'b1; n++)
			@(posedge CLK_I);
		if (n == 50)
			hang();
		chk(DMA_DATA_O & (32'hffffffff >> (32 - 8 * int'(v))), d);
		chk(DMA_VALID_BYTES_O, v);
		chk(DMA_EOR_O, e);
		@(posedge CLK_I);
	endtask

	// Signals the end of the descriptor chain.
	task automatic chain();
		DMA_CHAIN_END_I <= 1'b1;
		@(posedge CLK_I);
		DMA_CHAIN_END_I <= 1'b0;
	endtask

	// Main sequence.
	initial
	begin
		repeat (4) @(posedge CLK_I);
		RST_I <= 1'b0;
		@(posedge CLK_I);
		chk(RTS_N_O, 1'b1);
		rchk(`A_FIFO_CTRL, 32'h3fff, `RST_FIFO_CTRL);
		rchk(`A_DIVISOR, 32'hffff, `RST_DIVISOR);
		rchk(`A_IDENT, 32'hf, `IID_NONE);
		apb(1'b0, 8'hfc, 32'h0);
		chk(slv, 1'b1);
		// Packing on the wide path, split reads and a read beyond the fill level.
		apb(1'b1, `A_MODEM_CTRL, 32'h2);
		apb(1'b1, `A_FIFO_CTRL, 32'h0821);
		txn(5, 8'h11);
		rchk(`A_OCCUPANCY, 32'h7f, 32'h5);
		rchk(`A_RXD4, 32'hffffffff, 32'h14131211);
		rchk(`A_RXD2, 32'hff, 32'h15);
		rchk(`A_OCCUPANCY, 32'h7f, 32'h0);
		txn(3, 8'h21);
		rchk(`A_RXD2, 32'hffff, 32'h2221);
		rchk(`A_RXD1, 32'hff, 32'h23);
		// The narrow path moves one byte in the lowest lane.
		apb(1'b1, `A_FIFO_CTRL, 32'h0801);
		txn(2, 8'h61);
		rchk(`A_RXD4, 32'hff, 32'h61);
		rchk(`A_OCCUPANCY, 32'h7f, 32'h1);
		rchk(`A_RXD1, 32'hff, 32'h62);
		// Full flow control against a threshold of four.
		apb(1'b1, `A_FIFO_CTRL, 32'h0401);
		apb(1'b1, `A_MODEM_CTRL, 32'h22);
		txn(3, 8'h30);
		chk(RTS_N_O, 1'b0);
		txn(1, 8'h33);
		repeat (2) @(posedge CLK_I);
		chk(RTS_N_O, 1'b1);
		rchk(`A_IDENT, 32'hf, `IID_DATA);
		rchk(`A_RXD1, 32'hff, 32'h30);
		chk(RTS_N_O, 1'b0);
		for (i = 1; i < 4; i++)
			rchk(`A_RXD1, 32'hff, 32'h30 + i);
		// Clear-to-send gating, then no gating with flow control off.
		apb(1'b1, `A_MODEM_CTRL, 32'h20);
		@(posedge CLK_I);
		chk(RTS_N_O, 1'b1);
		TX_REQ_I <= 1'b1;
		g = go_cnt;
		repeat (20) @(posedge CLK_I);
		chk(go_cnt - g, 0);
		CTS_N_I <= 1'b0;
		repeat (4) @(posedge CLK_I);
		chk(go_cnt > g, 1'b1);
		CTS_N_I <= 1'b1;
		apb(1'b1, `A_MODEM_CTRL, 32'h2);
		g = go_cnt;
		repeat (4) @(posedge CLK_I);
		chk(go_cnt > g, 1'b1);
		TX_REQ_I <= 1'b0;
		// Threshold service, then an errored entry halting requests until drained.
		apb(1'b1, `A_IRQ_EN, 32'h1);
		apb(1'b1, `A_FIFO_CTRL, 32'h0421);
		txn(4, 8'h01);
		wreq(50);
		ack(32'h04030201, 3'h4, 1'b0);
		remote_tx_inst.send(8'h09, 3'h1, 2);
		txn(4, 8'h0a);
		repeat (20) @(posedge CLK_I);
		chk(DMA_RX_REQ_O, 1'b0);
		chain();
		rchk(`A_IDENT, 32'h2f, `IID_LINE);
		rchk(`A_RXD1, 32'hff, 32'h09);
		wreq(50);
		ack(32'h0d0c0b0a, 3'h4, 1'b0);
		// Trailing bytes: one more byte keeps the end flag, two more reach the threshold.
		apb(1'b1, `A_IRQ_EN, 32'h3);
		apb(1'b1, `A_FIFO_CTRL, 32'h0431);
		for (i = 1; i < 3; i++)
		begin
			txn(2, 8'he1);
			wreq(5000);
			chk(DMA_REQ_BYTES_O, 7'h2);
			rchk(`A_IDENT, 32'h1f, 32'h1c);
			txn(i, 8'he3);
			ack(i == 1 ? 32'h00e3e2e1 : 32'he4e3e2e1, 3'(i + 2), i == 1);
		end
		txn(1, 8'hf1);
		wreq(5000);
		chain();
		rchk(`A_IDENT, 32'h3f, 32'h38);
		rchk(`A_RXD1, 32'hff, 32'hf1);
		// Start-bit measurement in formula, table and slow infrared modes.
		apb(1'b1, `A_IRQ_EN, 32'h4);
		apb(1'b1, `A_AB_CTRL, 32'h1);
		remote_tx_inst.send(8'h41, 3'h0, 800);
		rchk(`A_IDENT, 32'h40, 32'h40);
		rchk(`A_DIVISOR, 32'hffff, 32'h0000_0032);
		chk(DIV_O, 16'h0032);
		rchk(`A_AB_CTRL, 32'h1, 32'h0);
		apb(1'b0, `A_AB_COUNT, 32'h0);
		chk(rdat > 32'h0000_031e && rdat < 32'h0000_0322, 1'b1);
		apb(1'b1, `A_AB_CTRL, 32'h3);
		remote_tx_inst.send(8'h41, 3'h0, 1700);
		rchk(`A_DIVISOR, 32'hffff, `DIV_9600);
		apb(1'b1, `A_AB_CTRL, 32'h5);
		remote_tx_inst.send(8'h41, 3'h0, 800);
		rchk(`A_DIVISOR, 32'hffff, `DIV_9600);
		final_report();
	end
endmodule // testbench
